// *** logic/adc_frame.sv ***
// serial converter frame control, sampling and readout
//
// Function
// - A frame starts on the select fall alone; no serial clock pulse is needed.
// - The input is tracked from the select fall until the 3rd clock fall.
// - From the 3rd clock fall the sample is held and digitised.
// - At the 16th clock fall the data output is released and the frame ends.
// - Each frame carries four zero bits and then ten result bits.
// - The result goes out most significant bit first.
// - Result codes are plain straight binary from 000 to 3FF.
// - The conversion steps are paced by the serial clock alone.
// - The result in a frame is the sample taken in that frame.
// - After conversion the converter powers down until the next select fall.
// - With select high the device is shut down and the output is released.
// - After that first rise the next clocked frame gives a valid result.
// - Select gates the clock, starts conversion and frames the data.
`timescale 1ns/1ps
`default_nettype none
module adc_frame (
	input wire logic MCLK, // 40 MHz system clock
	input wire logic RESETN, // async reset, active low
	input wire logic CS_N, // chip select pin, active low
	input wire logic SCLK, // serial clock pin
	input wire logic [9:0] ANALOG_CODE, // quantised analog input level
	output logic RESULT_OUTPUT, // serial data out
	output logic RESULT_OUTPUT_OE, // high while data pin driven
	output logic TRACKING, // input being tracked
	output logic CONVERTER_ON, // converter powered
	output logic FRAME_VALID // frame result trusted
);

	// ==========================================
	// pin synchronisers
	logic [1:0] cs_sync_ff;
	logic [1:0] sclk_sync_ff;
	logic sclk_prev_ff;
	logic cs_prev_ff;

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			cs_sync_ff <= 2'h3;
			// clock parks high: no false fall after reset
			sclk_sync_ff <= 2'h3;
			cs_prev_ff <= 1'b1;
			sclk_prev_ff <= 1'b1;
		end else begin
			cs_sync_ff <= {cs_sync_ff[0], CS_N};
			sclk_sync_ff <= {sclk_sync_ff[0], SCLK};
			cs_prev_ff <= cs_sync_ff[1];
			sclk_prev_ff <= sclk_sync_ff[1];
		end
	end

	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	assign cs_low = !cs_sync_ff[1];
	assign cs_fall = cs_prev_ff && !cs_sync_ff[1];
	assign cs_rise = !cs_prev_ff && cs_sync_ff[1];
	// clock gated by select
	assign sclk_fall = cs_low && sclk_prev_ff && !sclk_sync_ff[1];

	// ==========================================
	// frame state
	typedef enum logic [1:0] {IDLE, TRACK, CONVERT, DONE} phase_e;
	phase_e phase_ff;
	logic [4:0] edge_cnt_ff;
	logic counting;

	// data window: msb after the fall that follows the sample
	localparam logic [4:0] FIRST_DATA_EDGE =
		adc_frame_pkg::SAMPLE_END_EDGE + adc_frame_pkg::EDGE_ONE;
	localparam logic [4:0] LAST_DATA_EDGE =
		adc_frame_pkg::SAMPLE_END_EDGE + 5'(adc_frame_pkg::RESULT_BITS);

	// falls outside track and convert are refused
	assign counting = sclk_fall
		&& (phase_ff == TRACK || phase_ff == CONVERT);

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			phase_ff <= IDLE;
			edge_cnt_ff <= adc_frame_pkg::EDGE_ZERO;
		end else if (!cs_low) begin
			phase_ff <= IDLE;
			edge_cnt_ff <= adc_frame_pkg::EDGE_ZERO;
		end else if (cs_fall) begin
			phase_ff <= TRACK;
			edge_cnt_ff <= adc_frame_pkg::EDGE_ZERO;
		end else if (counting) begin
			edge_cnt_ff <= edge_cnt_ff + adc_frame_pkg::EDGE_ONE;
			case (phase_ff)
				TRACK: begin
					if (edge_cnt_ff + adc_frame_pkg::EDGE_ONE
						== adc_frame_pkg::SAMPLE_END_EDGE)
						phase_ff <= CONVERT;
				end
				CONVERT: begin
					if (edge_cnt_ff + adc_frame_pkg::EDGE_ONE
						== adc_frame_pkg::FRAME_END_EDGE)
						phase_ff <= DONE;
				end
				default: phase_ff <= phase_ff;
			endcase
		end
	end

	// ==========================================
	// sample hold and shift out
	logic [9:0] track_ff;
	logic [9:0] held_ff;
	logic out_ff;
	logic oe_ff;

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			track_ff <= adc_frame_pkg::RESULT_RESET;
		end else if (phase_ff == TRACK) begin
			track_ff <= ANALOG_CODE;
		end
	end

	// bit shown after fall n: zeros around the result, msb first
	function automatic logic pick_bit(input logic [4:0] n,
		input logic [9:0] v);
		logic [4:0] idx;
		idx = adc_frame_pkg::EDGE_ZERO;
		if (n < FIRST_DATA_EDGE || n > LAST_DATA_EDGE) begin
			pick_bit = 1'b0;
		end else begin
			idx = LAST_DATA_EDGE - n;
			pick_bit = v[idx[3:0]];
		end
	endfunction : pick_bit

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			held_ff <= adc_frame_pkg::RESULT_RESET;
			out_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else if (!cs_low) begin
			out_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else if (cs_fall) begin
			out_ff <= 1'b0; // first leading zero
			oe_ff <= 1'b1;
		end else if (counting) begin
			if (edge_cnt_ff + adc_frame_pkg::EDGE_ONE
				== adc_frame_pkg::SAMPLE_END_EDGE)
				held_ff <= track_ff;
			if (edge_cnt_ff + adc_frame_pkg::EDGE_ONE
				>= adc_frame_pkg::FRAME_END_EDGE) begin
				oe_ff <= 1'b0;
				out_ff <= 1'b0;
			end else begin
				// fourth zero comes with the sampling fall
				out_ff <= pick_bit(edge_cnt_ff + adc_frame_pkg::EDGE_ONE,
					held_ff);
			end
		end
	end

	// ==========================================
	// power-up validity
	logic init_seen_ff;
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN)
			init_seen_ff <= 1'b0;
		else if (cs_rise)
			init_seen_ff <= 1'b1;
	end

	logic valid_ff;
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN)
			valid_ff <= 1'b0;
		else if (cs_fall)
			valid_ff <= init_seen_ff;
	end

	assign RESULT_OUTPUT = out_ff;
	assign RESULT_OUTPUT_OE = oe_ff;
	assign TRACKING = (phase_ff == TRACK);
	assign CONVERTER_ON = (phase_ff == TRACK) || (phase_ff == CONVERT);
	assign FRAME_VALID = valid_ff;

	// ==========================================
	// checks
	property p_release_at_end;
		@(posedge MCLK) disable iff (!RESETN)
		(counting && edge_cnt_ff + adc_frame_pkg::EDGE_ONE
			== adc_frame_pkg::FRAME_END_EDGE) |=> !RESULT_OUTPUT_OE;
	endproperty
	a_release_at_end: assert property (p_release_at_end)
		else $error("output not released at frame end");

	property p_high_z_when_deselected;
		@(posedge MCLK) disable iff (!RESETN)
		!cs_low |=> !RESULT_OUTPUT_OE;
	endproperty
	a_high_z_when_deselected: assert property (p_high_z_when_deselected)
		else $error("output driven while deselected");

	property p_hold_at_third;
		@(posedge MCLK) disable iff (!RESETN)
		(counting && phase_ff == TRACK
			&& edge_cnt_ff + adc_frame_pkg::EDGE_ONE
			== adc_frame_pkg::SAMPLE_END_EDGE)
			|=> phase_ff == CONVERT && held_ff == $past(track_ff);
	endproperty
	a_hold_at_third: assert property (p_hold_at_third)
		else $error("sample not held at third fall");

	property p_lead_zeros;
		@(posedge MCLK) disable iff (!RESETN)
		(RESULT_OUTPUT_OE && edge_cnt_ff < FIRST_DATA_EDGE) |-> !RESULT_OUTPUT;
	endproperty
	a_lead_zeros: assert property (p_lead_zeros)
		else $error("leading bit not zero");

	property p_msb_first;
		@(posedge MCLK) disable iff (!RESETN)
		(counting && edge_cnt_ff == adc_frame_pkg::SAMPLE_END_EDGE)
			|=> RESULT_OUTPUT == held_ff[adc_frame_pkg::RESULT_BITS - 1];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("bit order wrong");

	property p_no_clock_no_progress;
		@(posedge MCLK) disable iff (!RESETN)
		(cs_low && !cs_fall && !sclk_fall) |=> $stable(edge_cnt_ff);
	endproperty
	a_no_clock_no_progress: assert property (p_no_clock_no_progress)
		else $error("frame advanced without clock");

	property p_power_down;
		@(posedge MCLK) disable iff (!RESETN)
		(counting && edge_cnt_ff + adc_frame_pkg::EDGE_ONE
			== adc_frame_pkg::FRAME_END_EDGE) |=> !CONVERTER_ON;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("converter on after conversion");

	property p_track_from_fall;
		@(posedge MCLK) disable iff (!RESETN)
		(cs_low && cs_fall) |=> TRACKING;
	endproperty
	a_track_from_fall: assert property (p_track_from_fall)
		else $error("tracking not started");

	property p_valid_after_init;
		@(posedge MCLK) disable iff (!RESETN)
		(cs_fall && init_seen_ff) |=> FRAME_VALID;
	endproperty
	a_valid_after_init: assert property (p_valid_after_init)
		else $error("frame not valid after init rise");

	property p_lsb_last;
		@(posedge MCLK) disable iff (!RESETN)
		(counting && edge_cnt_ff + adc_frame_pkg::EDGE_ONE == LAST_DATA_EDGE)
			|=> RESULT_OUTPUT == held_ff[0];
	endproperty
	a_lsb_last: assert property (p_lsb_last)
		else $error("last result bit wrong");

	property p_trailing_zero;
		@(posedge MCLK) disable iff (!RESETN)
		(counting && edge_cnt_ff >= LAST_DATA_EDGE
			&& edge_cnt_ff + adc_frame_pkg::EDGE_ONE
			< adc_frame_pkg::FRAME_END_EDGE) |=> !RESULT_OUTPUT;
	endproperty
	a_trailing_zero: assert property (p_trailing_zero)
		else $error("bit after result not zero");

	property p_stay_down;
		@(posedge MCLK) disable iff (!RESETN)
		(!CONVERTER_ON && !cs_fall) |=> !CONVERTER_ON;
	endproperty
	a_stay_down: assert property (p_stay_down)
		else $error("converter woke without select fall");

	property p_drive_from_fall;
		@(posedge MCLK) disable iff (!RESETN)
		cs_fall |=> RESULT_OUTPUT_OE && !RESULT_OUTPUT;
	endproperty
	a_drive_from_fall: assert property (p_drive_from_fall)
		else $error("output not driven low at select fall");

	property p_bit_stands;
		@(posedge MCLK) disable iff (!RESETN)
		(RESULT_OUTPUT_OE && cs_low && !counting && !cs_fall)
			|=> $stable(RESULT_OUTPUT);
	endproperty
	a_bit_stands: assert property (p_bit_stands)
		else $error("output bit changed between falls");

	property p_first_frame_untrusted;
		@(posedge MCLK) disable iff (!RESETN)
		(cs_fall && !init_seen_ff) |=> !FRAME_VALID;
	endproperty
	a_first_frame_untrusted: assert property (p_first_frame_untrusted)
		else $error("frame trusted before init rise");

	property p_count_cleared;
		@(posedge MCLK) disable iff (!RESETN)
		!cs_low |=> edge_cnt_ff == adc_frame_pkg::EDGE_ZERO;
	endproperty
	a_count_cleared: assert property (p_count_cleared)
		else $error("fall count kept while deselected");

endmodule : adc_frame
`default_nettype wire

// *** include/adc_frame_pkg.sv ***
// constants for the serial converter frame logic
package adc_frame_pkg;
	localparam int RESULT_BITS = 10;
	localparam int LEAD_ZEROS = 4;
	localparam logic [4:0] SAMPLE_END_EDGE = 5'h03;
	localparam logic [4:0] FRAME_END_EDGE = 5'h10;
	localparam logic [4:0] EDGE_ZERO = 5'h00;
	localparam logic [4:0] EDGE_ONE = 5'h01;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [9:0] MID_SCALE = 10'h200;
endpackage : adc_frame_pkg

// *** verif/adc_host_model.sv ***
// host model: drives select and serial clock, captures serial data
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
	input wire logic mclk, // system clock
	input wire logic result_output, // device data out
	input wire logic sdo_oe, // device drive enable
	output logic cs_n, // chip select, active low
	output logic sclk // serial clock
);
	logic last;
	logic [16:0] shift;
	wire pin = sdo_oe ? result_output : ~last; // released line shows no stale level
	always @(posedge mclk) begin
		if (sdo_oe) last <= result_output;
	end
	initial begin
		cs_n = 1'b0;
		sclk = 1'b1;
		last = 1'b0;
		shift = 17'h00000;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask : wt
	// select high, clock parked high
	task automatic idle();
		cs_n = 1'b1;
		sclk = 1'b1;
		shift = 17'h00000;
		wt(8);
	endtask : idle
	// opens the frame if deselected, then n falls, data taken on rises
	task automatic frame(input int n);
		if (cs_n) begin
			cs_n = 1'b0;
			wt(8);
			shift = {shift[15:0], pin};
		end
		repeat (n) begin
			sclk = 1'b0;
			wt(8);
			sclk = 1'b1;
			shift = {shift[15:0], pin};
			wt(8);
		end
	endtask : frame
endmodule : adc_host_model
`default_nettype wire

// *** verif/adc_frame_tb.sv ***
// testbench for the serial converter frame logic
`timescale 1ns/1ps
`default_nettype none
module adc_frame_tb;
	logic MCLK;
	logic RESETN;
	logic [9:0] code;
	logic cs_n;
	logic sclk;
	logic result_output;
	logic oe;
	logic trk;
	logic pon;
	logic fv;
	int num_errors = 0;
	int checked = 0;
	adc_frame i_dut (.MCLK(MCLK), .RESETN(RESETN), .CS_N(cs_n), .SCLK(sclk),
		.ANALOG_CODE(code), .RESULT_OUTPUT(result_output), .RESULT_OUTPUT_OE(oe),
		.TRACKING(trk), .CONVERTER_ON(pon), .FRAME_VALID(fv));
	adc_host_model i_host (.mclk(MCLK), .result_output(result_output), .sdo_oe(oe),
		.cs_n(cs_n), .sclk(sclk));
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	// power-up frame untrusted, select rise shuts down
	task automatic t_power();
		chk(fv, 1'b0);
		i_host.idle();
		chk(oe, 1'b0);
		chk(pon, 1'b0);
	endtask : t_power
	// select low without clock must not progress; abort mid-frame
	task automatic t_noclk();
		i_host.frame(0);
		i_host.wt(40);
		chk(trk, 1'b1);
		chk(oe, 1'b1);
		i_host.frame(6);
		chk(trk, 1'b0);
		i_host.idle();
		chk(oe, 1'b0);
		chk(pon, 1'b0);
	endtask : t_noclk
	// reset in mid-frame clears outputs; next frame untrusted
	task automatic t_reset();
		i_host.idle();
		i_host.frame(5);
		RESETN = 1'b0;
		i_host.wt(2);
		chk(oe, 1'b0);
		chk(pon, 1'b0);
		chk(fv, 1'b0);
		RESETN = 1'b1;
		i_host.wt(8);
		chk(trk, 1'b1);
		chk(oe, 1'b1);
		chk(fv, 1'b0);
		i_host.frame(16);
		chk(oe, 1'b0);
		chk(pon, 1'b0);
	endtask : t_reset
	// full frames; input changed after sampling must not show
	task automatic t_codes();
		logic [9:0] codes [5] = '{10'h000, 10'h200, 10'h1FF, 10'h3FF, 10'h155};
		foreach (codes[i]) begin
			code = codes[i];
			i_host.idle();
			i_host.frame(2);
			chk(trk, 1'b1);
			i_host.frame(1);
			chk(trk, 1'b0);
			chk(pon, 1'b1);
			code = ~codes[i];
			i_host.frame(13);
			chk(i_host.shift[16:3], {4'h0, codes[i]});
			chk(i_host.shift[0], 1'b1);
			chk(oe, 1'b0);
			chk(pon, 1'b0);
			chk(fv, 1'b1);
		end
	endtask : t_codes
	initial begin
		repeat (20000) @(posedge MCLK);
		num_errors++;
		results();
	end
	initial begin
		RESETN = 1'b0;
		code = 10'h000;
		repeat (2) @(posedge MCLK);
		@(negedge MCLK) RESETN = 1'b1;
		i_host.wt(8);
		t_power();
		t_noclk();
		t_reset();
		t_codes();
		results();
	end
endmodule : adc_frame_tb
`default_nettype wire
